/* File: design/ts_map.svh */
// offsets, field masks, reset values and counts of the two-wire slave
`ifndef TS_MAP_SVH
`define TS_MAP_SVH
`define TS_PTR_TEMP 2'h0
`define TS_PTR_CFG 2'h1
`define TS_PTR_HYST 2'h2
`define TS_PTR_OS 2'h3
`define TS_CFG_RST 8'h00
`define TS_HYST_RST 16'h4b00
`define TS_OS_RST 16'h5000
`define TS_CFG_MASK 8'h7f
`define TS_NIB_MASK 16'hfff0
`define TS_BIT_LAST 4'h8
`define TS_BIT_ZERO 4'h0
`define TS_BIT_ONE 4'h1
`define TS_IDX_CTRL 3'h0
`define TS_IDX_PTR 3'h1
`define TS_IDX_MSB 3'h2
`define TS_IDX_LSB 3'h3
`define TS_IDX_EXTRA 3'h4
`define TS_BYTE_ZERO 8'h00
`endif

/* File: design/ts_pkg.sv */
// types shared by the two-wire slave
package ts_pkg;
  typedef enum logic [2:0] {
    TS_IDLE,
    TS_RECV,
    TS_ACK,
    TS_SEND,
    TS_ACKIN,
    TS_WAIT
  } ts_state_t;
endpackage : ts_pkg

/* File: design/ts_cdc_word.sv */
// toggle handshake that carries a word between two clock domains
`timescale 1ns/1ps
module ts_cdc_word #(
  parameter int WIDTH = 16
) (
  input wire logic srcClk,
  input wire logic srcRstn,
  input wire logic [WIDTH-1:0] srcData,
  input wire logic dstClk,
  input wire logic dstRstn,
  output logic [WIDTH-1:0] dstData
);
  logic [WIDTH-1:0] hold;
  logic reqTgl;
  logic ackMeta;
  logic ackSync;
  logic reqMeta;
  logic reqSync;
  logic reqSeen;
  wire srcIdle = (ackSync == reqTgl);
  wire dstNew = (reqSync != reqSeen);

  // hold stays still while a toggle is in flight
  always_ff @(posedge srcClk) begin
    if (!srcRstn) begin
      hold <= '0;
      reqTgl <= 1'b0;
    end else if (srcIdle) begin
      hold <= srcData;
      reqTgl <= ~reqTgl;
    end
  end

  always_ff @(posedge srcClk) begin
    if (!srcRstn) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
    end else begin
      ackMeta <= reqSeen;
      ackSync <= ackMeta;
    end
  end

  always_ff @(posedge dstClk) begin
    if (!dstRstn) begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
    end else begin
      reqMeta <= reqTgl;
      reqSync <= reqMeta;
    end
  end

  always_ff @(posedge dstClk) begin
    if (!dstRstn) begin
      dstData <= '0;
      reqSeen <= 1'b0;
    end else if (dstNew) begin
      dstData <= hold;
      reqSeen <= reqSync;
    end
  end
endmodule : ts_cdc_word

/* File: design/ts_two_wire_slave.sv */
// two-wire serial slave of the thermometer with its register storage
`timescale 1ns/1ps
`include "ts_map.svh"
module ts_two_wire_slave #(
  parameter logic [3:0] DEV_TYPE = 4'h5 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_link,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic selectPinHigh,
  input wire logic selectPinMid,
  input wire logic selectPinLow,
  input wire logic [15:0] tempValue,
  output logic [7:0] cfgValue,
  output logic [15:0] hystSetpoint,
  output logic [15:0] osSetpoint
);
  ts_pkg::ts_state_t state;
  ts_pkg::ts_state_t next_state;
  logic linkRstMeta;
  logic linkRstn;
  logic sclMeta;
  logic sclS;
  logic sclQ;
  logic sdaMeta;
  logic sdaS;
  logic sdaQ;
  logic [2:0] selMeta;
  logic [2:0] selS;
  logic [3:0] bitCnt;
  logic [2:0] byteIdx;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic [7:0] msbStage;
  logic [15:0] holdWord;
  logic [15:0] tempLink;
  logic [1:0] pointer;
  logic [7:0] cfgReg;
  logic [15:0] hystReg;
  logic [15:0] osReg;
  logic readMode;
  logic byteSel;
  logic masterAck;
  logic next_sdaOe;
  logic [39:0] regsSys;

  function automatic logic [15:0] regWord(input logic [1:0] ptr, input logic [15:0] temp,
                                          input logic [7:0] cfg, input logic [15:0] hyst,
                                          input logic [15:0] os);
    case (ptr)
      `TS_PTR_TEMP: regWord = temp;
      `TS_PTR_CFG: regWord = {cfg, `TS_BYTE_ZERO};
      `TS_PTR_HYST: regWord = hyst;
      default: regWord = os;
    endcase
  endfunction : regWord

  function automatic logic [7:0] readByte(input logic [15:0] word, input logic sel);
    readByte = sel ? word[7:0] : word[15:8];
  endfunction : readByte

  function automatic logic [2:0] satInc(input logic [2:0] idx);
    satInc = (idx == `TS_IDX_EXTRA) ? idx : idx + 3'h1;
  endfunction : satInc

  // link reset follows rstn into the link domain
  always_ff @(posedge clk_link) begin
    linkRstMeta <= rstn;
    linkRstn <= linkRstMeta;
  end

  // 8 MHz sampling gives about twenty samples per fast-rate bit
  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      sclMeta <= 1'b1;
      sclS <= 1'b1;
      sclQ <= 1'b1;
      sdaMeta <= 1'b1;
      sdaS <= 1'b1;
      sdaQ <= 1'b1;
      selMeta <= 3'h0;
      selS <= 3'h0;
    end else begin
      sclMeta <= sclIn;
      sclS <= sclMeta;
      sclQ <= sclS;
      sdaMeta <= sdaIn;
      sdaS <= sdaMeta;
      sdaQ <= sdaS;
      selMeta <= {selectPinHigh, selectPinMid, selectPinLow};
      selS <= selMeta;
    end
  end

  // clock is only ever an input here
  wire sclRise = sclS && !sclQ;
  wire sclFall = !sclS && sclQ;
  wire sclHigh = sclS && sclQ;
  wire startCond = sclHigh && sdaQ && !sdaS;
  wire stopCond = sclHigh && !sdaQ && sdaS;
  wire inRecv = (state == ts_pkg::TS_RECV);
  wire inSend = (state == ts_pkg::TS_SEND);
  wire rxDone = inRecv && (bitCnt == `TS_BIT_LAST) && sclFall;
  wire isCtrl = (byteIdx == `TS_IDX_CTRL);
  wire addrMatch = (rxShift[7:4] == DEV_TYPE) && (rxShift[3:1] == selS);
  wire isRead = rxShift[0];
  wire ackThis = !isCtrl || addrMatch;
  wire ackEnd = (state == ts_pkg::TS_ACK) && sclFall;
  wire txDone = inSend && sclFall && (bitCnt == `TS_BIT_LAST);
  wire mAckEnd = (state == ts_pkg::TS_ACKIN) && sclFall;
  wire nextSel = (pointer == `TS_PTR_CFG) ? 1'b0 : !byteSel;
  wire txLoad = (ackEnd && readMode) || (mAckEnd && masterAck);
  wire [7:0] txNext = readByte(holdWord, ackEnd ? 1'b0 : nextSel);
  wire bitClear = startCond || ackEnd || mAckEnd;
  wire wrByte = rxDone && !isCtrl && !readMode;
  wire [15:0] setWord = {msbStage, rxShift} & `TS_NIB_MASK;

  always_comb begin
    next_state = state;
    if (startCond) begin
      next_state = ts_pkg::TS_RECV;
    end else if (stopCond) begin
      next_state = ts_pkg::TS_IDLE;
    end else begin
      case (state)
        ts_pkg::TS_RECV: begin
          if (rxDone) begin
            next_state = ackThis ? ts_pkg::TS_ACK : ts_pkg::TS_WAIT;
          end
        end
        ts_pkg::TS_ACK: begin
          if (sclFall) begin
            next_state = readMode ? ts_pkg::TS_SEND : ts_pkg::TS_RECV;
          end
        end
        ts_pkg::TS_SEND: begin
          if (txDone) begin
            next_state = ts_pkg::TS_ACKIN;
          end
        end
        ts_pkg::TS_ACKIN: begin
          if (sclFall) begin
            next_state = masterAck ? ts_pkg::TS_SEND : ts_pkg::TS_WAIT;
          end
        end
        ts_pkg::TS_IDLE: next_state = state;
        ts_pkg::TS_WAIT: next_state = state;
        default: next_state = ts_pkg::TS_IDLE;
      endcase
    end
  end

  // pull-down only: every change except the release at a start or stop lands just after a clock fall
  always_comb begin
    next_sdaOe = sdaOe;
    if (startCond || stopCond) begin
      next_sdaOe = 1'b0;
    end else if (rxDone) begin
      next_sdaOe = ackThis;
    end else if (txLoad) begin
      next_sdaOe = !txNext[7];
    end else if (ackEnd || mAckEnd) begin
      next_sdaOe = 1'b0;
    end else if (inSend && sclFall) begin
      next_sdaOe = txDone ? 1'b0 : !txShift[6];
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      state <= ts_pkg::TS_IDLE;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      state <= next_state;
      sdaOe <= next_sdaOe;
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn || bitClear) begin
      bitCnt <= `TS_BIT_ZERO;
    end else if (sclRise && (inRecv || inSend)) begin
      bitCnt <= bitCnt + `TS_BIT_ONE;
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn || startCond) begin
      byteIdx <= `TS_IDX_CTRL;
    end else if (rxDone) begin
      byteIdx <= satInc(byteIdx);
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      rxShift <= `TS_BYTE_ZERO;
    end else if (inRecv && sclRise) begin
      rxShift <= {rxShift[6:0], sdaS};
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      txShift <= `TS_BYTE_ZERO;
    end else if (txLoad) begin
      txShift <= txNext;
    end else if (inSend && sclFall) begin
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      masterAck <= 1'b0;
    end else if ((state == ts_pkg::TS_ACKIN) && sclRise) begin
      masterAck <= !sdaS;
    end
  end

  // snapshot at address time so msb and lsb never tear
  always_ff @(posedge clk_link) begin
    if (!linkRstn || startCond) begin
      readMode <= 1'b0;
      byteSel <= 1'b0;
    end else if (rxDone && isCtrl) begin
      readMode <= isRead && addrMatch;
      byteSel <= 1'b0;
    end else if (mAckEnd && masterAck) begin
      byteSel <= nextSel;
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      holdWord <= {`TS_BYTE_ZERO, `TS_BYTE_ZERO};
    end else if (rxDone && isCtrl) begin
      holdWord <= regWord(pointer, tempLink & `TS_NIB_MASK, cfgReg, hystReg, osReg);
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      pointer <= `TS_PTR_TEMP;
    end else if (wrByte && (byteIdx == `TS_IDX_PTR)) begin
      pointer <= rxShift[1:0];
    end
  end

  // temperature stays read-only, writes to it are acknowledged and dropped
  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      cfgReg <= `TS_CFG_RST;
      msbStage <= `TS_BYTE_ZERO;
    end else if (wrByte && (byteIdx == `TS_IDX_MSB)) begin
      msbStage <= rxShift;
      if (pointer == `TS_PTR_CFG) begin
        cfgReg <= rxShift & `TS_CFG_MASK;
      end
    end
  end

  always_ff @(posedge clk_link) begin
    if (!linkRstn) begin
      hystReg <= `TS_HYST_RST;
      osReg <= `TS_OS_RST;
    end else if (wrByte && (byteIdx == `TS_IDX_LSB)) begin
      if (pointer == `TS_PTR_HYST) begin
        hystReg <= setWord;
      end
      if (pointer == `TS_PTR_OS) begin
        osReg <= setWord;
      end
    end
  end

  ts_cdc_word #(
    .WIDTH(16)
  ) u_temp_cdc (
    .srcClk(clk_sys),
    .srcRstn(rstn),
    .srcData(tempValue),
    .dstClk(clk_link),
    .dstRstn(linkRstn),
    .dstData(tempLink)
  );

  ts_cdc_word #(
    .WIDTH(40)
  ) u_regs_cdc (
    .srcClk(clk_link),
    .srcRstn(linkRstn),
    .srcData({cfgReg, hystReg, osReg}),
    .dstClk(clk_sys),
    .dstRstn(rstn),
    .dstData(regsSys)
  );

  assign cfgValue = regsSys[39:32];
  assign hystSetpoint = regsSys[31:16];
  assign osSetpoint = regsSys[15:0];

  sequence s_rx_done;
    inRecv && (bitCnt == `TS_BIT_LAST) && sclFall;
  endsequence

  sequence s_addr_byte;
    byteIdx == `TS_IDX_CTRL;
  endsequence

  property p_start_restart;
    @(posedge clk_link) disable iff (!linkRstn)
    startCond |=> (state == ts_pkg::TS_RECV) && (byteIdx == `TS_IDX_CTRL) && !sdaOe && !readMode;
  endproperty
  a_start_restart: assert property (p_start_restart) else $error("start did not restart reception");

  property p_stop_idle;
    @(posedge clk_link) disable iff (!linkRstn)
    (stopCond && !startCond) |=> (state == ts_pkg::TS_IDLE) && !sdaOe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle");

  property p_resend_restart;
    @(posedge clk_link) disable iff (!linkRstn)
    (inSend && startCond) |=> inRecv ##0 !sdaOe;
  endproperty
  a_resend_restart: assert property (p_resend_restart) else $error("repeated start not taken");

  property p_no_match_release;
    @(posedge clk_link) disable iff (!linkRstn)
    (s_rx_done ##0 s_addr_byte ##0 !addrMatch && !startCond) |=> !sdaOe [*2];
  endproperty
  a_no_match_release: assert property (p_no_match_release) else $error("unmatched address acknowledged");

  property p_data_ack;
    @(posedge clk_link) disable iff (!linkRstn)
    (s_rx_done ##0 !isCtrl && !startCond && !stopCond) |=> sdaOe && (state == ts_pkg::TS_ACK);
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("addressed byte not acknowledged");

  property p_ack_held;
    @(posedge clk_link) disable iff (!linkRstn)
    ((state == ts_pkg::TS_ACK) && sclHigh && !$past(startCond)) |-> sdaOe;
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("acknowledge released during clock high");

  property p_nack_release;
    @(posedge clk_link) disable iff (!linkRstn)
    ((state == ts_pkg::TS_ACKIN) && sclRise && sdaS) |-> !sdaOe ##1 !sdaOe [*4];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("data not released after nack");

  property p_tx_bit;
    @(posedge clk_link) disable iff (!linkRstn)
    (inSend && sclFall && (bitCnt != `TS_BIT_LAST) && !startCond && !stopCond) |=> (sdaOe == !$past(txShift[6]));
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("wrong transmit bit");

  property p_cfg_write;
    @(posedge clk_link) disable iff (!linkRstn)
    (wrByte && (byteIdx == `TS_IDX_MSB) && (pointer == `TS_PTR_CFG)) |=> (cfgReg == ($past(rxShift) & `TS_CFG_MASK));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write not stored");

  property p_ptr_reset;
    @(posedge clk_link) disable iff (!linkRstn)
    $rose(linkRstn) |-> (pointer == `TS_PTR_TEMP) && !sdaOe;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not at temperature after reset");

  property p_ptr_kept;
    @(posedge clk_link) disable iff (!linkRstn)
    !(wrByte && (byteIdx == `TS_IDX_PTR)) |=> $stable(pointer);
  endproperty
  a_ptr_kept: assert property (p_ptr_kept) else $error("pointer changed without pointer byte");

  property p_never_high;
    @(posedge clk_link) disable iff (!linkRstn)
    sdaOe |-> !sdaOut;
  endproperty
  a_never_high: assert property (p_never_high) else $error("data line driven high");
endmodule : ts_two_wire_slave

/* File: testbench/ts_bus_master.sv */
// behavioural two-wire bus master driving the slave's link
`timescale 1ns/1ps
module ts_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaPull
);
  // clk periods per scl phase; 32 keeps below the fast rate
  int half = 32;
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // also a repeated start when called with scl low
  task automatic start();
    if (!scl) begin
      sdaPull = 1'b0;
      wt(half);
      scl = 1'b1;
    end
    wt(half);
    sdaPull = 1'b1;
    wt(half);
    scl = 1'b0;
  endtask : start
  task automatic bitx(input logic b, output logic s);
    wt(half / 4);
    sdaPull = ~b;
    wt(half - half / 4);
    scl = 1'b1;
    wt(half);
    s = sda;
    scl = 1'b0;
  endtask : bitx
  task automatic stop();
    wt(half / 4);
    sdaPull = 1'b1;
    wt(half - half / 4);
    scl = 1'b1;
    wt(half);
    sdaPull = 1'b0;
    wt(2 * half);
  endtask : stop
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask : sendByte
  task automatic recvByte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(~ack, s);
  endtask : recvByte
endmodule : ts_bus_master

/* File: testbench/tb_temp_sensor_two_wire_slave.sv */
// self-checking bench of the two-wire thermometer slave
`timescale 1ns/1ps
module tb_temp_sensor_two_wire_slave;
  localparam logic [3:0] TYPE_CODE = 4'h5; // arbitrary value
  logic clkSys = 1'b0;
  logic clkLink = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [15:0] tempValue = 16'h4b00;
  logic sclW;
  logic mstPull;
  logic dutOe;
  logic dutOut;
  logic [7:0] cfgValue;
  logic [15:0] hystSetpoint;
  logic [15:0] osSetpoint;
  int mismatches = 0;
  int nTests = 0;
  logic ackSeen;
  logic [7:0] rb;
  logic prevScl = 1'b1;
  logic prevOe = 1'b0;
  wire logic sdaW;
  // pull-up on the data wire, both parties only pull low
  assign sdaW = ~(dutOe | mstPull);

  ts_two_wire_slave #(.DEV_TYPE(TYPE_CODE)) dut (
    .clk_sys(clkSys), .rstn(rstn), .clk_link(clkLink), .sclIn(sclW), .sdaIn(sdaW),
    .sdaOut(dutOut), .sdaOe(dutOe), .selectPinHigh(sel[2]), .selectPinMid(sel[1]),
    .selectPinLow(sel[0]), .tempValue(tempValue), .cfgValue(cfgValue),
    .hystSetpoint(hystSetpoint), .osSetpoint(osSetpoint)
  );
  ts_bus_master master (.clk(clkSys), .sda(sdaW), .scl(sclW), .sdaPull(mstPull));

  initial begin
    forever #20 clkSys = ~clkSys;
  end
  // link clock offset so its edges never meet the system clock's
  initial begin
    #7.3;
    forever #62.5 clkLink = ~clkLink;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (mismatches == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (100000) @(posedge clkSys);
    mismatches++;
    finish_test();
  end

  // bus master only moves at falling edges, so rising edges see settled lines
  always @(posedge clkSys) begin
    if (rstn) begin
      check({15'h0, dutOut}, 16'h0);
      if (sclW && prevScl) check({15'h0, dutOe}, {15'h0, prevOe});
    end
    prevScl <= sclW;
    prevOe <= dutOe;
  end

  function automatic logic [7:0] ctrl(input logic rd);
    return {TYPE_CODE, sel, rd};
  endfunction : ctrl

  task automatic sendChk(input logic [7:0] d, input logic expAck);
    master.sendByte(d, ackSeen);
    check({15'h0, ackSeen}, {15'h0, expAck});
  endtask : sendChk

  task automatic wrReg(input logic [1:0] ptr, input logic [15:0] d);
    master.start();
    sendChk(ctrl(1'b0), 1'b1);
    sendChk({6'h0, ptr}, 1'b1);
    if (ptr == 2'h1) begin
      sendChk(d[7:0], 1'b1);
    end else begin
      sendChk(d[15:8], 1'b1);
      sendChk(d[7:0], 1'b1);
    end
    master.stop();
  endtask : wrReg

  task automatic rdReg(input logic newPtr, input logic [1:0] ptr, input logic [15:0] exp);
    if (newPtr) begin
      master.start();
      sendChk(ctrl(1'b0), 1'b1);
      sendChk({6'h0, ptr}, 1'b1);
    end
    master.start();
    sendChk(ctrl(1'b1), 1'b1);
    if (ptr == 2'h1) begin
      master.recvByte(1'b0, rb);
      check({8'h0, rb}, {8'h0, exp[7:0]});
    end else begin
      master.recvByte(1'b1, rb);
      check({8'h0, rb}, {8'h0, exp[15:8]});
      master.recvByte(1'b0, rb);
      check({8'h0, rb}, {8'h0, exp[7:0]});
    end
    master.wt(master.half / 2);
    check({15'h0, dutOe}, 16'h0);
    master.stop();
  endtask : rdReg

  // output copies lag the link side by a handshake
  task automatic settle(input logic [1:0] ptr, input logic [15:0] e);
    logic [15:0] v;
    for (int i = 0; i < 400; i++) begin
      @(negedge clkSys);
      v = (ptr == 2'h1) ? {8'h0, cfgValue} : (ptr == 2'h2) ? hystSetpoint : osSetpoint;
      if (v === e) break;
    end
    check(v, e);
    if (v !== e) finish_test();
  endtask : settle

  initial begin
    logic [15:0] d;
    int k;
    logic [15:0] tbl [6] = '{16'h5000, 16'h0a20, 16'h0080, 16'hff80, 16'he5e0, 16'hc900};
    void'($urandom(3444));
    sel = 3'($urandom);
    repeat (16) @(negedge clkSys);
    rstn = 1'b1;
    repeat (64) @(negedge clkSys);
    settle(2'h1, 16'h0000);
    settle(2'h2, 16'h4b00);
    settle(2'h3, 16'h5000);
    rdReg(1'b0, 2'h0, 16'h4b00);
    for (k = 0; k < 8; k++) begin
      d = (k < 6) ? tbl[k] : 16'($urandom);
      tempValue = d;
      repeat (80) @(negedge clkSys);
      rdReg(k == 0, 2'h0, d & 16'hfff0);
    end
    // repeated start while the low byte goes out; its bit 7 is high so the line is free
    tempValue = 16'hff80;
    repeat (80) @(negedge clkSys);
    master.start();
    sendChk(ctrl(1'b1), 1'b1);
    master.recvByte(1'b1, rb);
    check({8'h0, rb}, 16'h00ff);
    rdReg(1'b0, 2'h0, 16'hff80);
    // temperature is read-only: the write is acknowledged and dropped
    wrReg(2'h0, 16'h1230);
    rdReg(1'b0, 2'h0, 16'hff80);
    for (k = 0; k < 3; k++) begin
      d = (k == 0) ? 16'h00ff : 16'($urandom);
      wrReg(2'h1, d);
      settle(2'h1, {8'h0, d[7:0] & 8'h7f});
      rdReg(1'b1, 2'h1, {8'h0, d[7:0] & 8'h7f});
    end
    for (k = 0; k < 2; k++) begin
      d = 16'($urandom);
      wrReg(2'(2 + k), d);
      settle(2'(2 + k), d & 16'hfff0);
      rdReg(1'b1, 2'(2 + k), d & 16'hfff0);
    end
    // setpoint write cut short by a repeated start must not commit
    master.start();
    sendChk(ctrl(1'b0), 1'b1);
    sendChk(8'h03, 1'b1);
    sendChk(~d[15:8], 1'b1);
    rdReg(1'b0, 2'h3, d & 16'hfff0);
    check(osSetpoint, d & 16'hfff0);
    for (k = 1; k < 8; k++) begin
      master.start();
      sendChk(ctrl(1'b0) ^ (8'h01 << k), 1'b0);
      master.sendByte(8'h01, ackSeen);
      check({15'h0, ackSeen}, 16'h0);
      master.stop();
    end
    master.half = 125;
    rdReg(1'b0, 2'h3, d & 16'hfff0);
    // second reset mid-run: storage and pointer fall back to defaults
    master.half = 32;
    rstn = 1'b0;
    repeat (16) @(negedge clkSys);
    rstn = 1'b1;
    repeat (64) @(negedge clkSys);
    settle(2'h3, 16'h5000);
    settle(2'h2, 16'h4b00);
    rdReg(1'b0, 2'h0, 16'hff80);
    finish_test();
  end
endmodule : tb_temp_sensor_two_wire_slave
